// File: bench/gauge_host_model.sv
// Host side of the parameter port: word writes and reads.
// Assumes the block answers a read one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module gauge_host_model (
   input wire logic i_clock,
   input wire logic [15:0] i_prm_rdata,
   output logic o_prm_wr,
   output logic [7:0] o_prm_subclass,
   output logic [7:0] o_prm_offset,
   output logic [15:0] o_prm_wdata
);
   // --------------------------------------------------------------
   // Idle bus, then word access tasks
   // --------------------------------------------------------------
   initial begin
      o_prm_wr = 1'b0;
      o_prm_subclass = 8'h00;
      o_prm_offset = 8'h00;
      o_prm_wdata = 16'h0000;
   end
   // Host writes settings and also the learn status word of the gauge
   task automatic wr(input logic [7:0] sc, input logic [7:0] ofs, input logic [15:0] d);
      @(negedge i_clock);
      o_prm_subclass = sc;
      o_prm_offset = ofs;
      o_prm_wdata = d;
      o_prm_wr = 1'b1;
      @(negedge i_clock);
      o_prm_wr = 1'b0;
      o_prm_wdata = ~d;
   endtask
   // Address held until the answer is settled
   task automatic rd(input logic [7:0] sc, input logic [7:0] ofs, output logic [15:0] d);
      @(negedge i_clock);
      o_prm_subclass = sc;
      o_prm_offset = ofs;
      @(negedge i_clock);
      @(negedge i_clock);
      d = i_prm_rdata;
   endtask
endmodule
`default_nettype wire

// File: bench/gauge_load_model_relax_config_tb_top.sv
// Self-checking bench for the gauge configuration block.
// Assumes the design sources under logic/ and the host model.
`timescale 1ns/1ps
`default_nettype none
module gauge_load_model_relax_config_tb_top;
   import gauge_cfg_pkg::*;
   localparam int CPS = 10;
   logic i_clock = 1'b0, i_sys_rst, i_prm_wr, i_sample, i_load_mode, i_qmax_valid;
   logic i_charge_term, i_ctl_shutdown, i_ctl_hibernate, i_enter_hibernate, i_sleep_ok;
   logic [7:0] i_prm_subclass, i_prm_offset, i_chg_relax_s, i_quit_relax_s, o_learn_status;
   logic [15:0] i_prm_wdata, o_prm_rdata, i_design_capacity, i_design_energy, i_noload_comp;
   logic [15:0] i_reserve_cap_mah, i_reserve_cap_mwh, i_dsg_threshold, i_chg_threshold;
   logic [15:0] i_quit_current, i_dsg_relax_s, i_qmax_measured, i_full_charge_cap;
   logic [15:0] o_reserve_mah, o_reserve_mwh, o_qmax, o_remaining_cap, d;
   logic signed [15:0] i_target_rate_value, i_user_rate, o_load_value, o_avg_i_last, o_avg_p_last;
   logic [2:0] i_load_select;
   logic [1:0] o_wake_range;
   logic o_discharging, o_charging, o_relaxed, o_ocv_take, o_qmax_update, o_sleep_allow;
   logic o_reload_rm, o_wake_enable, o_use_thermistor, o_shutdown_enable_out;
   logic o_shutdown_enable_out_oe;
   meas_t i_meas;
   int fails = 0, checks = 0, k;
   logic [3:0] lsel [7] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE};
   logic [15:0] lexp [7] = '{16'hFED4, 16'h0320, 16'h0123, 16'h0456, 16'h0BB8, 16'h0123, 16'h0456};
   always #2 i_clock = ~i_clock;
   // Measurement strobe every other cycle
   always @(negedge i_clock) i_sample <= !i_sample && !i_sys_rst;
   gauge_load_model_relax_config #(.CYCLES_PER_S(CPS)) dut (.*);
   gauge_host_model host (.i_clock(i_clock), .i_prm_rdata(o_prm_rdata), .o_prm_wr(i_prm_wr),
      .o_prm_subclass(i_prm_subclass), .o_prm_offset(i_prm_offset), .o_prm_wdata(i_prm_wdata));
   // --------------------------------------------------------------
   // Compare and verdict
   // --------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #120000;
      fails++;
      stop_test;
   end
   // --------------------------------------------------------------
   // Test sequence
   // --------------------------------------------------------------
   initial begin
      i_sys_rst = 1'b1; i_sample = 1'b0; i_meas = '0; i_load_mode = 1'b0; i_load_select = 3'h1;
      i_target_rate_value = 16'h0123; i_user_rate = 16'h0456; i_design_capacity = 16'h0FA0;
      i_design_energy = 16'h3A98; i_reserve_cap_mah = 16'h0064; i_reserve_cap_mwh = 16'h00C8;
      i_noload_comp = 16'h0014; i_dsg_threshold = 16'h003C; i_chg_threshold = 16'h004B;
      i_quit_current = 16'h0028; i_dsg_relax_s = 16'h0002; i_chg_relax_s = 8'h03;
      i_quit_relax_s = 8'h01; i_qmax_measured = 16'h0000; i_qmax_valid = 1'b0;
      i_charge_term = 1'b0; i_full_charge_cap = 16'h05DC; i_ctl_shutdown = 1'b0;
      i_ctl_hibernate = 1'b0; i_enter_hibernate = 1'b0; i_sleep_ok = 1'b1;
      repeat (4) @(negedge i_clock);
      i_sys_rst = 1'b0;
      host.rd(8'h40, 8'h00, d);
      chk("pack_cfg", 16'h0137, d);
      chk("wake", 16'h0001, {13'h0000, o_wake_enable, o_wake_range});
      chk("therm", 16'h0001, {15'h0000, o_use_thermistor});
      chk("sleep", 16'h0001, {15'h0000, o_sleep_allow});
      chk("res_mah", 16'h0064, o_reserve_mah);
      host.wr(8'h40, 8'h00, 16'hFFFF);
      host.rd(8'h40, 8'h00, d);
      chk("pack_cfg", 16'h873D, d);
      chk("wake", 16'h0007, {13'h0000, o_wake_enable, o_wake_range});
      for (k = 0; k < 20 && o_reserve_mah !== 16'h0050; k++) @(negedge i_clock);
      chk("res_mah", 16'h0050, o_reserve_mah);
      chk("res_mwh", 16'h00B4, o_reserve_mwh);
      host.wr(8'h40, 8'h00, 16'h0000);
      host.rd(8'h40, 8'h00, d);
      chk("therm", 16'h0000, {15'h0000, o_use_thermistor});
      chk("sleep", 16'h0000, {15'h0000, o_sleep_allow});
      host.wr(8'h40, 8'h00, 16'h0137);
      host.rd(8'h41, 8'h00, d);
      chk("unmapped", 16'h0000, d);
      host.wr(8'h52, 8'h06, 16'h00FF);
      host.rd(8'h52, 8'h06, d);
      chk("learn_status", 16'h0001, d);
      host.wr(8'h52, 8'h06, 16'h0000);
      i_meas.avg_current = 16'hFED4;
      i_meas.current = 16'hFE0C;
      i_meas.voltage = 16'h0FA0;
      // Load codes 2, 4, 5 and 6 in current mode, codes 4 to 6 in power mode
      for (int j = 0; j < 7; j++) begin
         @(negedge i_clock);
         {i_load_mode, i_load_select} = lsel[j];
         for (k = 0; k < 20 && o_load_value !== lexp[j]; k++) @(negedge i_clock);
         chk("load_value", lexp[j], o_load_value);
      end
      i_meas.avg_current = 16'hFE0C;
      for (k = 0; k < 20 && o_discharging !== 1'b1; k++) @(negedge i_clock);
      chk("dsg", 16'h0001, {15'h0000, o_discharging});
      i_meas.avg_current = 16'h01F4;
      for (k = 0; k < 20 && o_charging !== 1'b1; k++) @(negedge i_clock);
      chk("chg", 16'h0001, {15'h0000, o_charging});
      chk("relaxed", 16'h0000, {15'h0000, o_relaxed});
      i_meas = '0;
      for (k = 0; k < 80 && o_relaxed !== 1'b1; k++) @(negedge i_clock);
      chk("relaxed", 16'h0001, {15'h0000, o_relaxed});
      chk("avg_i_last", 16'hFE0C, o_avg_i_last);
      chk("avg_p_last", 16'hFF38, o_avg_p_last);
      // Long relaxation: OCV after the wait, learning only with low dV/dt
      i_meas.dvdt = 16'h0004;
      i_qmax_valid = 1'b1;
      i_qmax_measured = 16'h0BB8;
      for (k = 0; k < 19000 && o_ocv_take !== 1'b1; k++) @(negedge i_clock);
      chk("ocv_take", 16'h0001, {15'h0000, o_ocv_take});
      chk("qmax", 16'h0000, o_qmax);
      i_meas.dvdt = 16'h0003;
      repeat (3) @(negedge i_clock);
      chk("qmax", 16'h0BB8, o_qmax);
      chk("learn_status", 16'h0001, {8'h00, o_learn_status});
      i_meas.avg_current = 16'h0064;
      for (k = 0; k < 60 && o_relaxed !== 1'b0; k++) @(negedge i_clock);
      chk("relaxed", 16'h0000, {15'h0000, o_relaxed});
      i_charge_term = 1'b1;
      @(negedge i_clock);
      i_charge_term = 1'b0;
      for (k = 0; k < 20 && o_remaining_cap !== 16'h05DC; k++) @(negedge i_clock);
      chk("rem_cap", 16'h05DC, o_remaining_cap);
      i_ctl_shutdown = 1'b1;
      i_ctl_hibernate = 1'b1;
      repeat (3) @(negedge i_clock);
      chk("se_pin", 16'h0001, {15'h0000, o_shutdown_enable_out_oe});
      chk("se_level", 16'h0000, {15'h0000, o_shutdown_enable_out});
      i_enter_hibernate = 1'b1;
      @(negedge i_clock);
      i_enter_hibernate = 1'b0;
      for (k = 0; k < 20 && o_shutdown_enable_out_oe !== 1'b0; k++) @(negedge i_clock);
      chk("se_pin", 16'h0000, {15'h0000, o_shutdown_enable_out_oe});
      stop_test;
   end
endmodule
`default_nettype wire

// File: logic/gauge_cfg_pkg.sv
// Types shared by the gauge configuration block.
// Assumes the constants header is available in logic/.
package gauge_cfg_pkg;
   typedef struct packed {
      logic reserve_comp_flag;
      logic current_wake_enable;
      logic sense_range_hi;
      logic sense_range_lo;
      logic sleep_enable;
      logic capacity_reload_on_full;
      logic shutdown_out_pullup;
      logic shutdown_out_polarity;
      logic thermistor_select;
   } pack_cfg_t;
   typedef struct packed {
      logic signed [15:0] current;
      logic [15:0] voltage;
      logic signed [15:0] avg_current;
      logic [15:0] dvdt;
   } meas_t;
   typedef enum logic [1:0] {
      RS_FLOWING = 2'b00,
      RS_RELAXED = 2'b01,
      RS_LEAVING = 2'b10
   } relax_state_t;
endpackage

// File: logic/gauge_cfg_regs.svh
// Constants of the gauge configuration block: fields, resets, timing.
// Assumes inclusion by bare name from logic/ sources.
`ifndef GAUGE_CFG_REGS_SVH
`define GAUGE_CFG_REGS_SVH
`define PACK_CFG_SUBCLASS 8'h40
`define PACK_CFG_OFFSET 8'h00
`define LEARN_STATUS_SUBCLASS 8'h52
`define LEARN_STATUS_OFFSET 8'h06
`define PACK_CFG_RESET 16'h0137
`define PACK_CFG_MASK 16'h873D
`define QMAX_SUBCLASS 8'h52
`define QMAX_OFFSET 8'h02
`define LEARN_STATUS_RESET 8'h00
`define LEARN_STATUS_MASK 8'h01
`define BIT_RESERVE_COMP 15
`define BIT_WAKE_EN 10
`define BIT_RANGE_HI 9
`define BIT_RANGE_LO 8
`define BIT_SLEEP_EN 5
`define BIT_RELOAD 4
`define BIT_PULLUP 3
`define BIT_POLARITY 2
`define BIT_THERM 0
`define LOAD_SEL_RESET_CURRENT 3'h1
`define LOAD_SEL_RESET_POWER 3'h0
`define CLK_HZ 250000000
`define OCV_WAIT_S 1800
`define DVDT_LIMIT_UV 16'h0004
`define FILTER_TAU_S 14
`define FILTER_SHIFT 4
`endif

// File: logic/gauge_cycle_avg.sv
// Running average over one discharge cycle, latched at the cycle end.
// Assumes samples arrive as one-cycle strobes while discharge flows.
`timescale 1ns/1ps
`default_nettype none
module gauge_cycle_avg (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_sample,
   input wire logic i_active,
   input wire logic signed [31:0] i_value,
   output logic signed [15:0] o_present,
   output logic signed [15:0] o_last
);
   logic signed [47:0] sum_r;
   logic [15:0] n_r;
   logic active_d_r;
   wire logic signed [47:0] sum_nxt = sum_r + {{16{i_value[31]}}, i_value};
   wire logic signed [47:0] quot = (n_r == 16'h0000) ? 48'sd0 : sum_r / $signed({32'd0, n_r});
   // Accumulate while active, log at falling edge of activity
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sum_r <= 48'sd0;
         n_r <= 16'h0000;
         active_d_r <= 1'b0;
         o_last <= 16'sd0;
         o_present <= 16'sd0;
      end else begin
         active_d_r <= i_active;
         o_present <= quot[15:0];
         if (active_d_r && !i_active) begin
            o_last <= quot[15:0];
            sum_r <= 48'sd0;
            n_r <= 16'h0000;
         end else if (i_active && i_sample && n_r != 16'hffff) begin
            sum_r <= sum_nxt;
            n_r <= n_r + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// File: logic/gauge_load_model_relax_config.sv
// Load model selection, reserve handling, current thresholds, relaxation
// tracking, capacity learning, cycle logging and shutdown pin control.
// Assumes parameters arrive over the host parameter port as subclass/offset
// writes, and that measurements are strobed once per sample period.
`include "gauge_cfg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Current mode picks load current by code
// - Power mode picks load power by code
// - Reserve capacity and energy kept from going below zero
// - Separate charge and discharge current thresholds
// - Relax after quiet current for relax time
// - OCV reading after thirty relaxed minutes
// - Capacity update needs dV/dt under four
// - Leave relax after quit relax time
// - Stored max capacity updated by device
// - Learn status bit zero set on learn
// - Log previous cycle average current
// - Log previous cycle average power
// - Pin driven low at reset, shutdown bit set or not
// - Hibernate with both bits releases pin
// - Pack configuration word layout at 64/0
// - Reserve flag applies no-load compensation
// - Wake detection from three bits, 0/0/1
// - Sleep allowed only when enabled
// - Reload remaining capacity on termination
// - Pin drive push-pull and polarity
// - Thermistor or internal sensor select
module gauge_load_model_relax_config #(
   parameter int unsigned CYCLES_PER_S = `CLK_HZ
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_prm_wr,
   input wire logic [7:0] i_prm_subclass,
   input wire logic [7:0] i_prm_offset,
   input wire logic [15:0] i_prm_wdata,
   output logic [15:0] o_prm_rdata,
   input wire logic i_sample,
   input wire gauge_cfg_pkg::meas_t i_meas,
   input wire logic i_load_mode,
   input wire logic [2:0] i_load_select,
   input wire logic signed [15:0] i_target_rate_value,
   input wire logic signed [15:0] i_user_rate,
   input wire logic [15:0] i_design_capacity,
   input wire logic [15:0] i_design_energy,
   input wire logic [15:0] i_reserve_cap_mah,
   input wire logic [15:0] i_reserve_cap_mwh,
   input wire logic [15:0] i_noload_comp,
   input wire logic [15:0] i_dsg_threshold,
   input wire logic [15:0] i_chg_threshold,
   input wire logic [15:0] i_quit_current,
   input wire logic [15:0] i_dsg_relax_s,
   input wire logic [7:0] i_chg_relax_s,
   input wire logic [7:0] i_quit_relax_s,
   input wire logic [15:0] i_qmax_measured,
   input wire logic i_qmax_valid,
   input wire logic i_charge_term,
   input wire logic [15:0] i_full_charge_cap,
   input wire logic i_ctl_shutdown,
   input wire logic i_ctl_hibernate,
   input wire logic i_enter_hibernate,
   input wire logic i_sleep_ok,
   output logic signed [15:0] o_load_value,
   output logic [15:0] o_reserve_mah,
   output logic [15:0] o_reserve_mwh,
   output logic o_discharging,
   output logic o_charging,
   output logic o_relaxed,
   output logic o_ocv_take,
   output logic o_qmax_update,
   output logic [15:0] o_qmax,
   output logic [7:0] o_learn_status,
   output logic signed [15:0] o_avg_i_last,
   output logic signed [15:0] o_avg_p_last,
   output logic o_sleep_allow,
   output logic o_reload_rm,
   output logic [15:0] o_remaining_cap,
   output logic o_wake_enable,
   output logic [1:0] o_wake_range,
   output logic o_use_thermistor,
   output logic o_shutdown_enable_out,
   output logic o_shutdown_enable_out_oe
);
   import gauge_cfg_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] mag16(input logic signed [15:0] v);
      mag16 = v[15] ? 16'(-v) : 16'(v);
   endfunction
   function automatic logic [15:0] fifth(input logic [15:0] v);
      fifth = 16'(v / 16'd5);
   endfunction

   // ------------------------------------------------------------
   // Pack configuration word and learn status
   // ------------------------------------------------------------
   logic [15:0] pack_cfg_r;
   logic [7:0] learn_status_r;
   pack_cfg_t cfg;
   wire logic hit_cfg = (i_prm_subclass == `PACK_CFG_SUBCLASS) &&
      (i_prm_offset == `PACK_CFG_OFFSET);
   wire logic hit_learn = (i_prm_subclass == `LEARN_STATUS_SUBCLASS) &&
      (i_prm_offset == `LEARN_STATUS_OFFSET);
   assign cfg.reserve_comp_flag = pack_cfg_r[`BIT_RESERVE_COMP];
   assign cfg.current_wake_enable = pack_cfg_r[`BIT_WAKE_EN];
   assign cfg.sense_range_hi = pack_cfg_r[`BIT_RANGE_HI];
   assign cfg.sense_range_lo = pack_cfg_r[`BIT_RANGE_LO];
   assign cfg.sleep_enable = pack_cfg_r[`BIT_SLEEP_EN];
   assign cfg.capacity_reload_on_full = pack_cfg_r[`BIT_RELOAD];
   assign cfg.shutdown_out_pullup = pack_cfg_r[`BIT_PULLUP];
   assign cfg.shutdown_out_polarity = pack_cfg_r[`BIT_POLARITY];
   assign cfg.thermistor_select = pack_cfg_r[`BIT_THERM];
   wire logic [15:0] cfg_mask = `PACK_CFG_MASK;
   wire logic learn_event;
   wire logic [15:0] rdata_nxt = hit_cfg ? pack_cfg_r :
      hit_learn ? {8'h00, learn_status_r} : 16'h0000;

   // Parameter storage; device learn event wins over host write
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         pack_cfg_r <= `PACK_CFG_RESET;
         learn_status_r <= `LEARN_STATUS_RESET;
         o_prm_rdata <= 16'h0000;
      end else begin
         o_prm_rdata <= rdata_nxt;
         if (i_prm_wr && hit_cfg)
            pack_cfg_r <= i_prm_wdata & cfg_mask;
         if (learn_event)
            learn_status_r <= learn_status_r | `LEARN_STATUS_MASK;
         else if (i_prm_wr && hit_learn)
            learn_status_r <= i_prm_wdata[7:0] & `LEARN_STATUS_MASK;
      end
   end

   // ------------------------------------------------------------
   // Seconds tick and cycle averages
   // ------------------------------------------------------------
   logic tick;
   logic signed [15:0] avg_i_now, avg_p_now, avg_i_last, avg_p_last;
   logic dsg_now;
   wire logic signed [31:0] inst_power = i_meas.current * $signed({1'b0, i_meas.voltage});
   wire logic signed [31:0] power_10mw = inst_power / 32'sd10000;
   gauge_seconds #(.CYCLES_PER_S(CYCLES_PER_S)) u_sec (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .o_tick(tick)
   );
   gauge_cycle_avg u_avg_i (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_sample(i_sample),
      .i_active(dsg_now),
      .i_value({{16{i_meas.current[15]}}, i_meas.current}),
      .o_present(avg_i_now),
      .o_last(avg_i_last)
   );
   gauge_cycle_avg u_avg_p (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_sample(i_sample),
      .i_active(dsg_now),
      .i_value(power_10mw),
      .o_present(avg_p_now),
      .o_last(avg_p_last)
   );

   // ------------------------------------------------------------
   // Current direction and filtered current
   // ------------------------------------------------------------
   logic signed [15:0] filt_r;
   wire logic signed [15:0] filt_step = 16'((i_meas.avg_current - filt_r) >>> `FILTER_SHIFT);
   assign dsg_now = i_meas.avg_current[15] &&
      (mag16(i_meas.avg_current) > i_dsg_threshold);
   wire logic chg_now = !i_meas.avg_current[15] &&
      (i_meas.avg_current > $signed(i_chg_threshold));
   wire logic quiet = mag16(i_meas.avg_current) < i_quit_current;

   // ------------------------------------------------------------
   // Load model selection
   // ------------------------------------------------------------
   wire logic signed [31:0] avg_pw = i_meas.avg_current * $signed({1'b0, i_meas.voltage});
   wire logic signed [31:0] flt_pw = filt_r * $signed({1'b0, i_meas.voltage});
   logic signed [15:0] load_nxt;
   always_comb begin
      load_nxt = 16'sd0;
      if (!i_load_mode) begin
         case (i_load_select)
            3'h0: load_nxt = avg_i_last;
            3'h1: load_nxt = avg_i_now;
            3'h2: load_nxt = i_meas.avg_current;
            3'h3: load_nxt = filt_r;
            3'h4: load_nxt = $signed(fifth(i_design_capacity));
            3'h5: load_nxt = i_target_rate_value;
            3'h6: load_nxt = i_user_rate;
            default: load_nxt = avg_i_now;
         endcase
      end else begin
         case (i_load_select)
            3'h0: load_nxt = avg_p_last;
            3'h1: load_nxt = avg_p_now;
            3'h2: load_nxt = 16'(avg_pw / 32'sd10000);
            3'h3: load_nxt = 16'(flt_pw / 32'sd10000);
            3'h4: load_nxt = $signed(fifth(i_design_energy));
            3'h5: load_nxt = i_target_rate_value;
            3'h6: load_nxt = i_user_rate;
            default: load_nxt = avg_p_last;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Reserve capacity with optional no-load compensation
   // ------------------------------------------------------------
   wire logic [15:0] res_mah_nxt = cfg.reserve_comp_flag ?
      ((i_reserve_cap_mah > i_noload_comp) ? 16'(i_reserve_cap_mah - i_noload_comp) : 16'h0000)
      : i_reserve_cap_mah;
   wire logic [15:0] res_mwh_nxt = cfg.reserve_comp_flag ?
      ((i_reserve_cap_mwh > i_noload_comp) ? 16'(i_reserve_cap_mwh - i_noload_comp) : 16'h0000)
      : i_reserve_cap_mwh;

   // ------------------------------------------------------------
   // Relaxation state machine
   // ------------------------------------------------------------
   relax_state_t rs_r, rs_nxt;
   logic [15:0] quiet_s_r, loud_s_r, relaxed_s_r;
   wire logic enter_relax = quiet && ((quiet_s_r >= i_dsg_relax_s) ||
      (quiet_s_r >= {8'h00, i_chg_relax_s}));
   wire logic leave_relax = !quiet && (loud_s_r >= {8'h00, i_quit_relax_s});
   wire logic ocv_ready = (rs_r != RS_FLOWING) && (relaxed_s_r >= 16'(`OCV_WAIT_S));
   wire logic qmax_ok = ocv_ready && (i_meas.dvdt < `DVDT_LIMIT_UV) && i_qmax_valid;
   assign learn_event = qmax_ok && !o_qmax_update;
   always_comb begin
      rs_nxt = rs_r;
      case (rs_r)
         RS_FLOWING: if (enter_relax) rs_nxt = RS_RELAXED;
         RS_RELAXED: if (!quiet) rs_nxt = RS_LEAVING;
         RS_LEAVING: begin
            if (quiet) rs_nxt = RS_RELAXED;
            else if (leave_relax) rs_nxt = RS_FLOWING;
         end
         default: rs_nxt = RS_FLOWING;
      endcase
   end
   // Second counters for quiet, loud and relaxed time
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rs_r <= RS_FLOWING;
         quiet_s_r <= 16'h0000;
         loud_s_r <= 16'h0000;
         relaxed_s_r <= 16'h0000;
         filt_r <= 16'sd0;
      end else begin
         rs_r <= rs_nxt;
         if (!quiet) quiet_s_r <= 16'h0000;
         else if (tick && quiet_s_r != 16'hffff) quiet_s_r <= quiet_s_r + 16'h0001;
         if (quiet) loud_s_r <= 16'h0000;
         else if (tick && loud_s_r != 16'hffff) loud_s_r <= loud_s_r + 16'h0001;
         if (rs_r == RS_FLOWING) relaxed_s_r <= 16'h0000;
         else if (tick && relaxed_s_r != 16'hffff) relaxed_s_r <= relaxed_s_r + 16'h0001;
         if (tick) filt_r <= 16'(filt_r + filt_step);
      end
   end

   // ------------------------------------------------------------
   // Shutdown pin: driven low at reset whether armed or not, released in hibernate
   // ------------------------------------------------------------
   wire logic se_release = i_enter_hibernate && i_ctl_hibernate && i_ctl_shutdown;
   logic se_released_r;
   wire logic se_level = cfg.shutdown_out_polarity ? se_released_r : !se_released_r;
   wire logic se_oe = cfg.shutdown_out_pullup ? 1'b1 : (se_level == 1'b0);

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_load_value <= 16'sd0;
         o_reserve_mah <= 16'h0000;
         o_reserve_mwh <= 16'h0000;
         o_discharging <= 1'b0;
         o_charging <= 1'b0;
         o_relaxed <= 1'b0;
         o_ocv_take <= 1'b0;
         o_qmax_update <= 1'b0;
         o_qmax <= 16'h0000;
         o_learn_status <= `LEARN_STATUS_RESET;
         o_avg_i_last <= 16'sd0;
         o_avg_p_last <= 16'sd0;
         o_sleep_allow <= 1'b0;
         o_reload_rm <= 1'b0;
         o_remaining_cap <= 16'h0000;
         o_wake_enable <= 1'b0;
         o_wake_range <= 2'b01;
         o_use_thermistor <= 1'b1;
         se_released_r <= 1'b0;
         o_shutdown_enable_out <= 1'b0;
         o_shutdown_enable_out_oe <= 1'b1;
      end else begin
         o_load_value <= load_nxt;
         o_reserve_mah <= res_mah_nxt;
         o_reserve_mwh <= res_mwh_nxt;
         o_discharging <= dsg_now;
         o_charging <= chg_now;
         o_relaxed <= (rs_r != RS_FLOWING);
         o_ocv_take <= ocv_ready && tick;
         o_qmax_update <= qmax_ok;
         if (i_prm_wr && i_prm_subclass == `QMAX_SUBCLASS && i_prm_offset == `QMAX_OFFSET)
            o_qmax <= i_prm_wdata;
         if (learn_event) o_qmax <= i_qmax_measured;
         o_learn_status <= learn_status_r;
         o_avg_i_last <= avg_i_last;
         o_avg_p_last <= avg_p_last;
         o_sleep_allow <= cfg.sleep_enable && i_sleep_ok;
         o_reload_rm <= i_charge_term && cfg.capacity_reload_on_full;
         if (i_charge_term && cfg.capacity_reload_on_full)
            o_remaining_cap <= i_full_charge_cap;
         o_wake_enable <= cfg.current_wake_enable;
         o_wake_range <= {cfg.sense_range_hi, cfg.sense_range_lo};
         o_use_thermistor <= cfg.thermistor_select;
         if (se_release) se_released_r <= 1'b1;
         if (i_ctl_shutdown || se_released_r) begin
            o_shutdown_enable_out <= se_level;
            o_shutdown_enable_out_oe <= se_oe;
         end else begin
            o_shutdown_enable_out <= !cfg.shutdown_out_polarity;
            o_shutdown_enable_out_oe <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_learn_sets_bit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      learn_event |=> learn_status_r[0]) else $error("learn bit not set");
   a_relax_entry: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (rs_r == RS_FLOWING && enter_relax) |=> ##2 o_relaxed) else $error("relax missed");
   a_relax_exit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      $fell(o_relaxed) |-> $past(loud_s_r, 2) >= {8'h00, i_quit_relax_s})
      else $error("left relax early");
   a_ocv_wait: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_ocv_take |-> $past(relaxed_s_r) >= 16'd1800) else $error("ocv too early");
   a_qmax_dvdt: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_qmax_update |-> $past(i_meas.dvdt) < 16'd4) else $error("qmax with dvdt");
   a_sleep_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_sleep_allow |-> $past(pack_cfg_r[5])) else $error("sleep not enabled");
   a_thresh_dsg: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_discharging |-> !o_charging) else $error("both directions");
   a_se_release: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (se_release && !cfg.shutdown_out_pullup) |=> ##1 !o_shutdown_enable_out_oe ||
      o_shutdown_enable_out == cfg.shutdown_out_polarity) else $error("pin not released");
   a_load_user: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (i_load_select == 3'h6) |=> o_load_value == $past(i_user_rate))
      else $error("user rate not used");
endmodule
`default_nettype wire

// File: logic/gauge_seconds.sv
// One-second tick generator from the system clock.
// Assumes a free running i_clock at the documented rate.
`include "gauge_cfg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module gauge_seconds #(
   parameter int unsigned CYCLES_PER_S = `CLK_HZ
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   output logic o_tick
);
   logic [31:0] count_r;
   wire logic wrap = (count_r == CYCLES_PER_S - 1);
   // Counter and one-cycle tick
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         count_r <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else begin
         count_r <= wrap ? 32'h0000_0000 : count_r + 32'h0000_0001;
         o_tick <= wrap;
      end
   end
endmodule
`default_nettype wire
